//--- hdl/qhbp_params.svh
// constants for the quad serial controller host bus port
`ifndef QHBP_PARAMS_SVH
`define QHBP_PARAMS_SVH
`define QHBP_NUM_REGS      64
`define QHBP_ADDR_W        6
`define QHBP_DATA_W        8
`define QHBP_NUM_CH        4
`define QHBP_ACK_DLY       2
`define QHBP_REG_RST       8'h00
`define QHBP_VEC_RST       8'h0F
`define QHBP_CUR_INT_RST   8'h00
// multi-use pin control register per channel: bits [2:0] pin0, [5:3] pin1
`define QHBP_PCR_BASE      6'h20
`define QHBP_PIN0_LSB      0
`define QHBP_PIN1_LSB      3
// mode register: bit 0 of 0x24 selects modified vector, 0x25 threshold
`define QHBP_VEC_ADDR      6'h24
`define QHBP_THR_ADDR      6'h25
`define QHBP_IEN_ADDR      6'h26
`define QHBP_COS_ADDR      6'h27
`define QHBP_TX_ADDR       6'h28
`define QHBP_IN_ADDR       6'h29
// current interrupt read back
`define QHBP_CUR_ADDR      6'h2A
`endif

//--- hdl/qhbp_pkg.sv
// types for the quad serial controller host bus port
package qhbp_pkg;
  typedef enum logic [1:0] {
    QHBP_IDLE,
    QHBP_WAIT,
    QHBP_ACK
  } qhbp_state_e;
  // multi-use pin modes; the clkin pair is pin one only, clock fed in
  typedef enum logic [2:0] {
    QHBP_PM_GPIN,
    QHBP_PM_CTS,
    QHBP_PM_CLK1X,
    QHBP_PM_CLK16X,
    QHBP_PM_GPOUT,
    QHBP_PM_CTIO,
    QHBP_PM_CLKIN1X,
    QHBP_PM_CLKIN16X
  } qhbp_pmode_e;
endpackage

//--- hdl/qhbp_host_port.sv
// host bus port: register access, acknowledge, vectored interrupts, pins
`timescale 1ns/1ps
`include "qhbp_params.svh"
module qhbp_host_port #(
  parameter int NCH = `QHBP_NUM_CH
) (
  input  wire logic           clk,
  input  wire logic           resetn,
  input  wire logic           chip_select_low,
  input  wire logic           read_strobe_low,
  input  wire logic           write_strobe_low,
  input  wire logic           int_ack_low,
  input  wire logic [5:0]     reg_addr,
  input  wire logic [7:0]     host_data_bus_in,
  output logic      [7:0]     host_data_bus_out,
  output logic                host_data_bus_oe,
  output logic                xfer_ack_low_out,
  output logic                xfer_ack_low_oe,
  output logic                int_request_low_out,
  output logic                int_request_low_oe,
  input  wire logic [NCH-1:0] chan_int_src,
  input  wire logic [7:0]     chan_int_level [NCH],
  input  wire logic [NCH-1:0] chan_tx_data,
  output logic      [NCH-1:0] serial_tx_out,
  input  wire logic [NCH-1:0] serial_rx_in,
  output logic      [NCH-1:0] chan_rx_data,
  input  wire logic [NCH-1:0] tx_clk1x,
  input  wire logic [NCH-1:0] tx_clk16x,
  input  wire logic [NCH-1:0] rx_clk1x,
  input  wire logic [NCH-1:0] rx_clk16x,
  input  wire logic [NCH-1:0] ct_out,
  output logic      [NCH-1:0] ct_in,
  output logic      [NCH-1:0] ext_tx_clk,
  output logic      [NCH-1:0] cts_in,
  input  wire logic [NCH-1:0] multi_pin_zero_in,
  output logic      [NCH-1:0] multi_pin_zero_out,
  output logic      [NCH-1:0] multi_pin_zero_oe,
  input  wire logic [NCH-1:0] multi_pin_one_in,
  output logic      [NCH-1:0] multi_pin_one_out,
  output logic      [NCH-1:0] multi_pin_one_oe
);
  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [3:0]     ctl_s1_r, ctl_s2_r;
  logic [5:0]     addr_s1_r, addr_s2_r;
  logic [7:0]     din_s1_r, din_s2_r;
  logic [NCH-1:0] rx_s1_r, rx_s2_r, p0_s1_r, p0_s2_r, p1_s1_r, p1_s2_r;
  logic [NCH-1:0] p0_d_r, p1_d_r;
  always_ff @(posedge clk) begin
    ctl_s1_r  <= {chip_select_low, read_strobe_low, write_strobe_low,
                  int_ack_low};
    ctl_s2_r  <= ctl_s1_r;
    addr_s1_r <= reg_addr;
    addr_s2_r <= addr_s1_r;
    din_s1_r  <= host_data_bus_in;
    din_s2_r  <= din_s1_r;
    rx_s1_r   <= serial_rx_in;
    rx_s2_r   <= rx_s1_r;
    p0_s1_r   <= multi_pin_zero_in;
    p0_s2_r   <= p0_s1_r;
    p1_s1_r   <= multi_pin_one_in;
    p1_s2_r   <= p1_s1_r;
    p0_d_r    <= p0_s2_r;
    p1_d_r    <= p1_s2_r;
  end
  wire cs_act  = ~ctl_s2_r[3];
  wire rd_req  = cs_act & ~ctl_s2_r[2];
  wire wr_req  = cs_act & ~ctl_s2_r[1];
  // chip select must be high during acknowledge; a selected cycle wins
  wire iak_req = ctl_s2_r[3] & ~ctl_s2_r[0];
  wire any_req = rd_req | wr_req | iak_req;

  // ----------------------------------------------------------------------
  // register file and access sequencer
  // ----------------------------------------------------------------------
  logic [7:0] regs_r [`QHBP_NUM_REGS];
  logic [7:0] current_int_reg_r, cos_r, dout_r, dout_nxt;
  logic [1:0] dly_r;
  logic       ack_en_r, ack_oe_r, irq_r, oe_r;
  qhbp_pkg::qhbp_state_e st_r, st_nxt;

  wire        vec_mod = regs_r[`QHBP_VEC_ADDR][0];
  wire [7:0]  thr     = regs_r[`QHBP_THR_ADDR];
  wire [7:0]  ien     = regs_r[`QHBP_IEN_ADDR];

  // highest channel above threshold becomes the current interrupt
  logic [7:0] win_ch;
  logic       win_any;
  always_comb begin
    win_ch  = 8'h00;
    win_any = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if (chan_int_src[i] && ien[i] && chan_int_level[i] > thr) begin
        win_ch  = 8'(i);
        win_any = 1'b1;
      end
    end
  end
  wire [7:0] vec_plain = `QHBP_VEC_RST;
  wire [7:0] vec_out   = vec_mod ? {vec_plain[7:2], win_ch[1:0]}
                                 : vec_plain;
  wire [7:0] in_word   = {p1_s2_r, p0_s2_r};
  wire [7:0] rd_word   = (addr_s2_r == `QHBP_COS_ADDR) ? cos_r :
                         (addr_s2_r == `QHBP_IN_ADDR)  ? in_word :
                         (addr_s2_r == `QHBP_CUR_ADDR) ? current_int_reg_r :
                         regs_r[addr_s2_r];
  wire       ack_done  = (dly_r == 2'(`QHBP_ACK_DLY - 1));

  always_comb begin
    st_nxt   = st_r;
    dout_nxt = dout_r;
    case (st_r)
      qhbp_pkg::QHBP_IDLE: if (any_req) st_nxt = qhbp_pkg::QHBP_WAIT;
      qhbp_pkg::QHBP_WAIT: begin
        if (!any_req) begin
          st_nxt = qhbp_pkg::QHBP_IDLE;
        end else if (ack_done) begin
          st_nxt   = qhbp_pkg::QHBP_ACK;
          dout_nxt = iak_req ? vec_out : rd_word;
        end
      end
      qhbp_pkg::QHBP_ACK: if (!any_req) st_nxt = qhbp_pkg::QHBP_IDLE;
      default: st_nxt = qhbp_pkg::QHBP_IDLE;
    endcase
  end
  wire enter_ack = (st_r == qhbp_pkg::QHBP_WAIT) && any_req && ack_done;
  wire leave_ack = (st_nxt != qhbp_pkg::QHBP_ACK);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_r     <= qhbp_pkg::QHBP_IDLE;
      dly_r    <= 2'h0;
      dout_r   <= 8'h00;
      current_int_reg_r <= `QHBP_CUR_INT_RST;
      ack_oe_r <= 1'b0;
      ack_en_r <= 1'b1;
      oe_r     <= 1'b0;
      irq_r    <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      dly_r  <= (st_r == qhbp_pkg::QHBP_WAIT) ? dly_r + 2'h1 : 2'h0;
      dout_r <= dout_nxt;
      if (enter_ack && iak_req) current_int_reg_r <= win_ch;
      oe_r   <= ~leave_ack & (rd_req | iak_req);
      ack_oe_r <= (st_nxt == qhbp_pkg::QHBP_ACK) & ack_en_r;
      irq_r  <= win_any;
    end
  end

  // write capture happens on entry to acknowledge, on the same edge that drives ack
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < `QHBP_NUM_REGS; i++) regs_r[i] <= `QHBP_REG_RST;
    end else if (enter_ack && wr_req) begin
      regs_r[addr_s2_r] <= din_s2_r;
    end
  end

  // change of state latches set; reading the register clears, set wins
  wire [7:0] cos_set = {p1_s2_r ^ p1_d_r, p0_s2_r ^ p0_d_r};
  wire       cos_clr = enter_ack && rd_req && addr_s2_r == `QHBP_COS_ADDR;
  always_ff @(posedge clk) begin
    if (!resetn) cos_r <= 8'h00;
    else         cos_r <= (cos_clr ? 8'h00 : cos_r) | cos_set;
  end

  // ----------------------------------------------------------------------
  // multi-use pins and serial lines
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      wire [7:0] pcr = regs_r[`QHBP_PCR_BASE + g];
      wire [2:0] m0  = pcr[`QHBP_PIN0_LSB +: 3];
      wire [2:0] m1  = pcr[`QHBP_PIN1_LSB +: 3];
      wire       gpo = regs_r[`QHBP_TX_ADDR][g];
      wire       ct_pin_out = (g % 2 == 1);
      wire p0_oe = (m0 == qhbp_pkg::QHBP_PM_CLK1X) ||
                   (m0 == qhbp_pkg::QHBP_PM_CLK16X) ||
                   (m0 == qhbp_pkg::QHBP_PM_GPOUT);
      wire p0_v  = (m0 == qhbp_pkg::QHBP_PM_CLK1X)  ? tx_clk1x[g] :
                   (m0 == qhbp_pkg::QHBP_PM_CLK16X) ? tx_clk16x[g] : gpo;
      wire p1_oe = (m1 == qhbp_pkg::QHBP_PM_CLK1X) ||
                   (m1 == qhbp_pkg::QHBP_PM_CLK16X) ||
                   (m1 == qhbp_pkg::QHBP_PM_GPOUT) ||
                   (m1 == qhbp_pkg::QHBP_PM_CTIO && ct_pin_out);
      wire p1_v  = (m1 == qhbp_pkg::QHBP_PM_CLK1X)  ? rx_clk1x[g] :
                   (m1 == qhbp_pkg::QHBP_PM_CLK16X) ? rx_clk16x[g] :
                   (m1 == qhbp_pkg::QHBP_PM_CTIO)   ? ct_out[g] : gpo;
      always_ff @(posedge clk) begin
        if (!resetn) begin
          multi_pin_zero_oe[g]  <= 1'b0;
          multi_pin_one_oe[g]   <= 1'b0;
          multi_pin_zero_out[g] <= 1'b0;
          multi_pin_one_out[g]  <= 1'b0;
          serial_tx_out[g]      <= 1'b1;
          chan_rx_data[g]       <= 1'b1;
          cts_in[g]             <= 1'b0;
          ext_tx_clk[g]         <= 1'b0;
          ct_in[g]              <= 1'b0;
        end else begin
          multi_pin_zero_oe[g]  <= p0_oe;
          multi_pin_one_oe[g]   <= p1_oe;
          multi_pin_zero_out[g] <= p0_v;
          multi_pin_one_out[g]  <= p1_v;
          serial_tx_out[g]      <= chan_tx_data[g];
          chan_rx_data[g]       <= rx_s2_r[g];
          cts_in[g]  <= (m0 == qhbp_pkg::QHBP_PM_CTS) & p0_s2_r[g];
          ext_tx_clk[g] <= (m1 == qhbp_pkg::QHBP_PM_CLKIN1X ||
                            m1 == qhbp_pkg::QHBP_PM_CLKIN16X) & p1_s2_r[g];
          ct_in[g] <= (m1 == qhbp_pkg::QHBP_PM_CTIO) & ~ct_pin_out
                      & p1_s2_r[g];
        end
      end
    end
  endgenerate

  // open drain pins only ever pull low
  always_comb begin
    host_data_bus_out   = dout_r;
    host_data_bus_oe    = oe_r;
    xfer_ack_low_out    = 1'b0;
    xfer_ack_low_oe     = ack_oe_r;
    int_request_low_out = 1'b0;
    int_request_low_oe  = irq_r;
  end
endmodule

//--- test/qhbp_checker.sv
// bus port assertions and their bind
`timescale 1ns/1ps
module qhbp_checker #(
  parameter int NCH = 4
) (
  input wire logic           clk,
  input wire logic           resetn,
  input wire logic           chip_select_low,
  input wire logic           read_strobe_low,
  input wire logic           write_strobe_low,
  input wire logic           int_ack_low,
  input wire logic           host_data_bus_oe,
  input wire logic           xfer_ack_low_out,
  input wire logic           xfer_ack_low_oe,
  input wire logic           int_request_low_out,
  input wire logic [NCH-1:0] multi_pin_zero_oe,
  input wire logic [NCH-1:0] multi_pin_one_oe,
  input wire logic [NCH-1:0] chan_tx_data,
  input wire logic [NCH-1:0] serial_tx_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // cs low during an acknowledge still counts as a request
  wire req  = !int_ack_low ||
              (!chip_select_low && !(read_strobe_low && write_strobe_low));
  wire idle = read_strobe_low && write_strobe_low && int_ack_low;
  a_ack_has_cause: assert property ($rose(xfer_ack_low_oe) |-> $past(req, 3))
    else $error("acknowledge rose without a request");
  a_ack_drive_low: assert property (xfer_ack_low_oe |-> !xfer_ack_low_out)
    else $error("acknowledge driven high");
  a_irq_open_drain: assert property (int_request_low_out == 1'b0)
    else $error("interrupt pin driven high");
  a_read_drives_bus: assert property ($rose(xfer_ack_low_oe) &&
    !read_strobe_low && !chip_select_low |-> host_data_bus_oe)
    else $error("read acknowledged without data");
  a_write_bus_free: assert property (xfer_ack_low_oe &&
    !write_strobe_low && !chip_select_low |-> !host_data_bus_oe)
    else $error("bus driven during write");
  a_ack_in_time: assert property ($rose(req) |-> ##[3:8] xfer_ack_low_oe)
    else $error("request not acknowledged in time");
  a_release_after: assert property ($rose(idle) |->
    ##[1:6] (!xfer_ack_low_oe && !host_data_bus_oe))
    else $error("acknowledge or bus not released");
  a_reset_inputs: assert property ($rose(resetn) |-> !xfer_ack_low_oe &&
    !(|multi_pin_zero_oe) && !(|multi_pin_one_oe))
    else $error("pins driven after reset");
  a_tx_follows: assert property ($past(resetn) |->
    serial_tx_out == $past(chan_tx_data))
    else $error("serial output does not follow channel");
  c_read: cover property ($rose(xfer_ack_low_oe) && !read_strobe_low);
  c_write: cover property ($rose(xfer_ack_low_oe) && !write_strobe_low);
  c_vector: cover property ($rose(xfer_ack_low_oe) && !int_ack_low);
endmodule

bind qhbp_host_port qhbp_checker #(.NCH(NCH)) qhbp_checker_i (
  .clk(clk), .resetn(resetn), .chip_select_low(chip_select_low),
  .read_strobe_low(read_strobe_low), .write_strobe_low(write_strobe_low),
  .int_ack_low(int_ack_low), .host_data_bus_oe(host_data_bus_oe),
  .xfer_ack_low_out(xfer_ack_low_out), .xfer_ack_low_oe(xfer_ack_low_oe),
  .int_request_low_out(int_request_low_out),
  .multi_pin_zero_oe(multi_pin_zero_oe), .multi_pin_one_oe(multi_pin_one_oe),
  .chan_tx_data(chan_tx_data), .serial_tx_out(serial_tx_out));

//--- test/qhbp_host_model.sv
// host processor model for the asynchronous register port
`timescale 1ns/1ps
module qhbp_host_model (
  input  wire logic       clk,
  input  wire logic       ack_wire,
  input  wire logic [7:0] bus_wire,
  output logic            chip_select_low,
  output logic            read_strobe_low,
  output logic            write_strobe_low,
  output logic            int_ack_low,
  output logic [5:0]      reg_addr,
  output logic [7:0]      host_data_drv
);
  logic       hen;
  logic [7:0] wdata;
  logic [7:0] junk;
  // an undriven bus shows a changing pattern, never the last value
  assign host_data_drv = hen ? wdata : junk;
  initial begin
    {chip_select_low, read_strobe_low, write_strobe_low, int_ack_low} = 4'hF;
    reg_addr = 6'h00;
    wdata = 8'h00;
    hen = 1'b0;
    junk = 8'h5A;
  end
  always @(posedge clk) junk <= ~junk;
  // kind 0 read, 1 write, 2 interrupt acknowledge
  task automatic xfer(input logic [1:0] k, input logic [5:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge clk);
    chip_select_low <= (k == 2'd2);
    read_strobe_low <= (k != 2'd0);
    write_strobe_low <= (k != 2'd1);
    int_ack_low <= (k != 2'd2);
    reg_addr <= a;
    wdata <= d;
    hen <= (k == 2'd1);
    n = 0;
    do begin @(posedge clk); n++; end while (ack_wire !== 1'b0 && n < 40);
    q = (n < 40) ? bus_wire : 8'hXX;
    {chip_select_low, read_strobe_low, write_strobe_low, int_ack_low} <= 4'hF;
    hen <= 1'b0;
    n = 0;
    do begin @(posedge clk); n++; end while (ack_wire !== 1'b1 && n < 40);
  endtask
endmodule

//--- test/tb_quad_uart_host_bus_port.sv
// self-checking bench for the host bus port
`timescale 1ns/1ps
module tb_quad_uart_host_bus_port;
  logic       clk, resetn;
  wire        cs_l, rd_l, wr_l, iack_l, doe, ack_out, ack_oe, irq_oe, ack_w;
  wire  [5:0] addr;
  wire  [7:0] drv, dout, bus;
  wire  [3:0] txo, rxo, p0oe, p1oe, p0o, p1o, cti, xck, ctsi;
  logic [3:0] src, txd, rxi, p0i, p1i;
  logic [3:0] ck1, ck16, cto;
  logic [7:0] lvl [4];
  logic [7:0] q;
  int         fail_count, comparisons, cyc;
  assign bus = doe ? dout : drv;
  assign ack_w = ack_oe ? ack_out : 1'b1;
  qhbp_host_model host_i (.clk(clk), .ack_wire(ack_w), .bus_wire(bus),
    .chip_select_low(cs_l), .read_strobe_low(rd_l), .write_strobe_low(wr_l),
    .int_ack_low(iack_l), .reg_addr(addr), .host_data_drv(drv));
  qhbp_host_port qhbp_host_port_i (.clk(clk), .resetn(resetn),
    .chip_select_low(cs_l), .read_strobe_low(rd_l), .write_strobe_low(wr_l),
    .int_ack_low(iack_l), .reg_addr(addr), .host_data_bus_in(bus),
    .host_data_bus_out(dout), .host_data_bus_oe(doe),
    .xfer_ack_low_out(ack_out), .xfer_ack_low_oe(ack_oe),
    .int_request_low_out(), .int_request_low_oe(irq_oe),
    .chan_int_src(src), .chan_int_level(lvl), .chan_tx_data(txd),
    .serial_tx_out(txo), .serial_rx_in(rxi), .chan_rx_data(rxo),
    .tx_clk1x(ck1), .tx_clk16x(ck16), .rx_clk1x(ck1), .rx_clk16x(ck16),
    .ct_out(cto), .ct_in(cti), .ext_tx_clk(xck), .cts_in(ctsi),
    .multi_pin_zero_in(p0i), .multi_pin_zero_out(p0o),
    .multi_pin_zero_oe(p0oe), .multi_pin_one_in(p1i),
    .multi_pin_one_out(p1o), .multi_pin_one_oe(p1oe));
  initial begin clk = 1'b0; forever #5 clk = ~clk; end
  task automatic check(input string nm, input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // cycle ceiling well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin fail_count++; summarize(); end
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host_i.xfer(2'd1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a);
    host_i.xfer(2'd0, a, 8'h00, q);
  endtask
  task automatic t_regs();
    rd(6'h28);
    check("reset value", q, 8'h00);
    wr(6'h28, 8'hA5);
    wr(6'h26, 8'h3C);
    rd(6'h28);
    check("reg 28", q, 8'hA5);
    rd(6'h26);
    check("reg 26", q, 8'h3C);
  endtask
  task automatic t_irq();
    lvl[1] <= 8'h10;
    src <= 4'b0010;
    wr(6'h25, 8'h0F);
    wr(6'h26, 8'h02);
    repeat (4) @(posedge clk);
    check("irq above", {7'h0, irq_oe}, 8'h01);
    host_i.xfer(2'd2, 6'h00, 8'h00, q);
    check("plain vector", q, 8'h0F);
    wr(6'h24, 8'h01);
    host_i.xfer(2'd2, 6'h00, 8'h00, q);
    check("modified vector", q, 8'h0D);
    rd(6'h2A);
    check("current int", q, 8'h01);
    lvl[1] <= 8'h0F;
    repeat (4) @(posedge clk);
    check("irq at threshold", {7'h0, irq_oe}, 8'h00);
  endtask
  task automatic t_pins();
    wr(6'h20, 8'h04);
    rd(6'h27);
    p0i <= 4'hB;
    repeat (6) @(posedge clk);
    check("pin0 out", {4'h0, p0oe}, 8'h01);
    check("pin1 in", {4'h0, p1oe}, 8'h00);
    rd(6'h27);
    check("change seen", q, 8'h04);
    rd(6'h27);
    check("change cleared", q, 8'h00);
    txd <= 4'hA;
    rxi <= 4'h5;
    repeat (5) @(posedge clk);
    check("serial tx", {4'h0, txo}, 8'h0A);
    check("serial rx", {4'h0, rxo}, 8'h05);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    check("pins after reset", {p0oe, p1oe}, 8'h00);
  endtask
  task automatic t_modes();
    ck1 <= 4'h2;
    ck16 <= 4'hC;
    cto <= 4'h2;
    wr(6'h20, 8'h29);
    wr(6'h21, 8'h2A);
    wr(6'h22, 8'h33);
    wr(6'h23, 8'h1C);
    wr(6'h28, 8'h08);
    repeat (3) @(posedge clk);
    check("pin0 drive", {4'h0, p0oe}, 8'h0E);
    check("pin1 drive", {4'h0, p1oe}, 8'h0A);
    check("pin0 clocks", {4'h0, p0o & 4'hE}, 8'h0E);
    check("pin1 clocks", {4'h0, p1o & 4'hA}, 8'h0A);
    check("cts in", {4'h0, ctsi}, 8'h01);
    check("counter in", {4'h0, cti}, 8'h01);
    check("tx clock in", {4'h0, xck}, 8'h04);
    {ck1, ck16, cto} <= 12'h000;
    repeat (3) @(posedge clk);
    check("pin0 idle", {4'h0, p0o & 4'hE}, 8'h08);
    check("pin1 idle", {4'h0, p1o & 4'hA}, 8'h00);
    rd(6'h29);
    check("pin levels", q, 8'hFB);
  endtask
  initial begin
    {resetn, src, txd, rxi, p0i, p1i} = {1'b0, 4'h0, 16'hFFFF};
    lvl = '{default: 8'h00};
    {ck1, ck16, cto} = 12'h000;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    check("oe at reset", {ack_oe, doe, irq_oe, p0oe, 1'b0}, 8'h00);
    t_regs();
    t_irq();
    t_pins();
    t_modes();
    summarize();
  end
endmodule
